// File: pcs_consts.svh
/*
 Bit positions, field codes and reset values of the 64-bit configuration
 word that steers the clock generator paths.
 Assumes the word is delivered whole by a serial loader outside the block.
*/
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_CFG_W 64
`define PCS_BIT_REF_SRC 12
`define PCS_BIT_SHUT 13
`define PCS_BIT_PD_REF 14
`define PCS_BIT_PD_FB 15
`define PCS_FB_SRC_HI 39
`define PCS_FB_SRC_LO 38
`define PCS_PUMP_HI 41
`define PCS_PUMP_LO 40
`define PCS_BIT_OUT_FILT 42
`define PCS_BIT_FILT_TIME 43
`define PCS_BIT_VCO_RANGE 44
`define PCS_BIT_OSC 45
`define PCS_ROUTE_HI 47
`define PCS_ROUTE_LO 46
`define PCS_BIT_PHASE_ADJ 48
`define PCS_BIT_CMOS 60
`define PCS_STAT_HI 63
`define PCS_STAT_LO 62
`define PCS_CFG_RESET 64'h0000_0000_0000_0000
`define PCS_PUMP_NA_X10_0 16'h000F
`define PCS_PUMP_NA_X10_1 16'h0032
`define PCS_PUMP_NA_X10_2 16'h0050
`define PCS_PUMP_NA_X10_3 16'h00F0
`define PCS_FILT_SHORT_NS 13500
`define PCS_FILT_LONG_NS 135000
`define PCS_CLK_NS 10
`endif

// File: pcs_pkg.sv
/*
 Types shared by the configuration decode block.
 Assumes pcs_consts.svh supplies all numeric values.
*/
package pcs_pkg;
   typedef enum logic [1:0] {
      PCS_FB_POST = 2'b00,
      PCS_FB_PIN_A = 2'b01,
      PCS_FB_VCO = 2'b10,
      PCS_FB_PIN_B = 2'b11
   } pcs_fb_src_e;
   typedef enum logic [1:0] {
      PCS_RT_VCO = 2'b00,
      PCS_RT_REFDIV = 2'b01,
      PCS_RT_PDIN = 2'b10,
      PCS_RT_XTAL = 2'b11
   } pcs_route_e;
   typedef enum logic [1:0] {
      PCS_ST_LOCK = 2'b00,
      PCS_ST_RANGE = 2'b01,
      PCS_ST_PHASE = 2'b10,
      PCS_ST_FBDIV = 2'b11
   } pcs_stat_e;
   typedef struct packed {
      logic xtal;
      logic ref_pin;
      logic ref_div;
      logic feedback_in_pin;
      logic fb_div;
      logic post_out;
      logic vco;
   } pcs_clk_s;
   typedef struct packed {
      logic xtal_locked;
      logic xtal_range_high;
      logic main_phase_aligned;
   } pcs_stat_s;
endpackage

// File: pcs_edge_remove.sv
/*
 Clock phase adjust: when enabled, removes every other rising edge of the
 sampled clock level, shifting its phase by gobbling an edge.
 Assumes clk_in_i is a level sampled on mclk_i.
*/
`timescale 1ns/1ns
module pcs_edge_remove
(
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_i,
   // Control and data.
   input wire logic enable_i,
   input wire logic clk_in_i,
   output logic clk_out_o
);
   logic prev_ff;
   logic skip_ff;
   logic nxt_skip;
   logic rise;

   assign rise = clk_in_i & ~prev_ff;

   always_comb
   begin
      nxt_skip = skip_ff;
      if (!enable_i)
      begin
         nxt_skip = 1'b0;
      end
      else if (rise)
      begin
         nxt_skip = ~skip_ff;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prev_ff <= 1'b0;
         skip_ff <= 1'b0;
      end
      else
      begin
         prev_ff <= clk_in_i;
         skip_ff <= nxt_skip;
      end
   end

   // The toggle is taken in the very cycle of the rise, so a gobbled high
   // phase stays low as a whole and no shortened pulse slips through.
   assign clk_out_o = enable_i ? (clk_in_i & ~nxt_skip) : clk_in_i;
endmodule

// File: pcs_cfg_select.sv
/*
 Configuration decode and clock path selection for the PLL clock generator.
 Assumes the configuration word is loaded elsewhere and the clock levels
 are synchronous to mclk_i.
*/
// Behaviour
// RULE_01 - Ref divider from crystal or ref pin; detector ref from divider or pin.
// RULE_02 - Detector feedback from divider or pin; feedback divider source decoded.
// RULE_03 - Shutdown bit one powers the main loop down; zero runs it.
// RULE_04 - Filter select bit picks internal or outside loop filter.
// RULE_05 - Oscillator bit picks low jitter or legacy oscillator.
// RULE_06 - Output route field picks VCO, ref divider, detector input, crystal.
// RULE_07 - Phase adjust bit removes clock edges; zero passes clock unchanged.
// RULE_08 - Style bit zero drives ECL; one drives CMOS and status pin.
// RULE_09 - Status mode field picks lock, range, phase or feedback divider.
// RULE_10 - In CMOS mode pin and upper status read-back both show status.
// RULE_11 - VCO range bit zero high speed, one low speed.
// RULE_12 - Pump current field selects 1.5, 5, 8 or 24 nanoamps.
// RULE_13 - Filter time bit selects 13.5 or 135 microsecond constant.
// RULE_14 - All selections follow the current word with no commit step.
`timescale 1ns/1ns
`include "pcs_consts.svh"
module pcs_cfg_select
(
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_i,
   // Configuration word.
   input wire logic [63:0] cfg_word_i,
   // Clock levels from pins and analog core.
   input wire pcs_pkg::pcs_clk_s clk_i,
   // Loop status from analog core.
   input wire pcs_pkg::pcs_stat_s stat_i,
   // Path steering.
   output logic ref_div_source_sel_o,
   output logic pd_reference_sel_o,
   output logic pd_feedback_sel_o,
   output logic [1:0] fb_div_source_sel_o,
   output logic ref_div_in_o,
   output logic pd_ref_in_o,
   output logic pd_fb_in_o,
   output logic fb_div_in_o,
   // Analog mode controls.
   output logic main_loop_shutdown_o,
   output logic outside_filter_sel_o,
   output logic oscillator_style_o,
   output logic vco_range_sel_o,
   output logic [1:0] main_pump_current_o,
   output logic [15:0] pump_na_x10_o,
   output logic filter_time_sel_o,
   output logic [31:0] filter_cycles_o,
   // Output clock.
   output logic [1:0] output_route_sel_o,
   output logic edge_remove_phase_adjust_o,
   output logic diff_clock_out_p_o,
   output logic diff_clock_out_n_o,
   output logic cmos_mode_o,
   // Status pin and read-back.
   output logic status_program_pin_o,
   output logic status_program_pin_oe_o,
   output logic stat_hi_read_o
);
   logic [63:0] cfg;
   pcs_pkg::pcs_fb_src_e fb_src;
   pcs_pkg::pcs_route_e route;
   pcs_pkg::pcs_stat_e stat_mode;
   logic ref_div_in, pd_ref_in, pd_fb_in, fb_div_in, route_clk, adj_clk;
   logic status_lvl;
   logic clk_p_ff, clk_n_ff, stat_ff, stat_rd_ff;
   logic nxt_clk_p, nxt_clk_n, nxt_stat, nxt_stat_rd;

   function automatic logic pick2(input logic [1:0] s, input logic a,
      input logic b, input logic c, input logic d);
      logic r;
      r = a;
      case (s)
         2'b00: r = a;
         2'b01: r = b;
         2'b10: r = c;
         default: r = d;
      endcase
      return r;
   endfunction

   // Decoding is purely combinational so a new word acts at once.
   assign cfg = cfg_word_i; // RULE_14
   assign fb_src = pcs_pkg::pcs_fb_src_e'(
      cfg[`PCS_FB_SRC_HI:`PCS_FB_SRC_LO]);
   assign route = pcs_pkg::pcs_route_e'(cfg[`PCS_ROUTE_HI:`PCS_ROUTE_LO]);
   assign stat_mode = pcs_pkg::pcs_stat_e'(cfg[`PCS_STAT_HI:`PCS_STAT_LO]);

   assign ref_div_in = cfg[`PCS_BIT_REF_SRC] ? clk_i.ref_pin
      : clk_i.xtal; // RULE_01
   assign pd_ref_in = cfg[`PCS_BIT_PD_REF] ? clk_i.ref_pin
      : clk_i.ref_div; // RULE_01
   assign pd_fb_in = cfg[`PCS_BIT_PD_FB] ? clk_i.feedback_in_pin
      : clk_i.fb_div; // RULE_02
   assign fb_div_in = pick2(fb_src, clk_i.post_out, clk_i.feedback_in_pin,
      clk_i.vco, clk_i.feedback_in_pin); // RULE_02
   // Route 10 shows the reference side of the phase detector.
   assign route_clk = pick2(route, clk_i.vco, clk_i.ref_div, pd_ref_in,
      clk_i.xtal); // RULE_06
   assign status_lvl = pick2(stat_mode, stat_i.xtal_locked,
      stat_i.xtal_range_high, stat_i.main_phase_aligned,
      clk_i.fb_div); // RULE_09

   pcs_edge_remove u_edge_remove
   (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .enable_i(cfg[`PCS_BIT_PHASE_ADJ]),
      .clk_in_i(route_clk),
      .clk_out_o(adj_clk)
   ); // RULE_07

   always_comb
   begin
      nxt_clk_p = adj_clk;
      nxt_clk_n = ~adj_clk;
      nxt_stat = status_lvl; // RULE_10
      nxt_stat_rd = cfg[`PCS_STAT_HI];
      if (cfg[`PCS_BIT_CMOS])
      begin
         nxt_stat_rd = status_lvl; // RULE_10
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         clk_p_ff <= 1'b0;
         clk_n_ff <= 1'b1;
         stat_ff <= 1'b0;
         stat_rd_ff <= 1'b0;
      end
      else
      begin
         clk_p_ff <= nxt_clk_p;
         clk_n_ff <= nxt_clk_n;
         stat_ff <= nxt_stat;
         stat_rd_ff <= nxt_stat_rd;
      end
   end

   assign ref_div_source_sel_o = cfg[`PCS_BIT_REF_SRC];
   assign pd_reference_sel_o = cfg[`PCS_BIT_PD_REF];
   assign pd_feedback_sel_o = cfg[`PCS_BIT_PD_FB];
   assign fb_div_source_sel_o = fb_src;
   assign ref_div_in_o = ref_div_in;
   assign pd_ref_in_o = pd_ref_in;
   assign pd_fb_in_o = pd_fb_in;
   assign fb_div_in_o = fb_div_in;
   assign main_loop_shutdown_o = cfg[`PCS_BIT_SHUT]; // RULE_03
   assign outside_filter_sel_o = cfg[`PCS_BIT_OUT_FILT]; // RULE_04
   assign oscillator_style_o = cfg[`PCS_BIT_OSC]; // RULE_05
   assign vco_range_sel_o = cfg[`PCS_BIT_VCO_RANGE]; // RULE_11
   assign main_pump_current_o = cfg[`PCS_PUMP_HI:`PCS_PUMP_LO];
   assign pump_na_x10_o =
      (cfg[`PCS_PUMP_HI:`PCS_PUMP_LO] == 2'b00) ? `PCS_PUMP_NA_X10_0 :
      (cfg[`PCS_PUMP_HI:`PCS_PUMP_LO] == 2'b01) ? `PCS_PUMP_NA_X10_1 :
      (cfg[`PCS_PUMP_HI:`PCS_PUMP_LO] == 2'b10) ? `PCS_PUMP_NA_X10_2 :
      `PCS_PUMP_NA_X10_3; // RULE_12
   assign filter_time_sel_o = cfg[`PCS_BIT_FILT_TIME];
   assign filter_cycles_o = cfg[`PCS_BIT_FILT_TIME]
      ? 32'(`PCS_FILT_LONG_NS / `PCS_CLK_NS)
      : 32'(`PCS_FILT_SHORT_NS / `PCS_CLK_NS); // RULE_13
   assign output_route_sel_o = route;
   assign edge_remove_phase_adjust_o = cfg[`PCS_BIT_PHASE_ADJ];
   assign diff_clock_out_p_o = clk_p_ff;
   // In CMOS style both legs carry the same phase instead of a pair.
   assign diff_clock_out_n_o = cfg[`PCS_BIT_CMOS] ? clk_p_ff
      : clk_n_ff; // RULE_08
   assign cmos_mode_o = cfg[`PCS_BIT_CMOS];
   assign status_program_pin_o = stat_ff;
   assign status_program_pin_oe_o = cfg[`PCS_BIT_CMOS]; // RULE_08
   assign stat_hi_read_o = stat_rd_ff;

   property p_shut;
      @(posedge mclk_i) disable iff (rst_i)
      main_loop_shutdown_o == cfg_word_i[`PCS_BIT_SHUT];
   endproperty
   a_shut: assert property (p_shut) else $error("shutdown mismatch"); // RULE_03

   property p_pdfb;
      @(posedge mclk_i) disable iff (rst_i)
      cfg_word_i[`PCS_BIT_PD_FB] |->
         pd_fb_in_o == clk_i.feedback_in_pin;
   endproperty
   a_pdfb: assert property (p_pdfb) else $error("feedback path wrong"); // RULE_02

   property p_refdiv;
      @(posedge mclk_i) disable iff (rst_i)
      !cfg_word_i[`PCS_BIT_REF_SRC] |-> ref_div_in_o == clk_i.xtal;
   endproperty
   a_refdiv: assert property (p_refdiv) else $error("ref source wrong"); // RULE_01

   property p_pin_oe;
      @(posedge mclk_i) disable iff (rst_i)
      status_program_pin_oe_o == cfg_word_i[`PCS_BIT_CMOS];
   endproperty
   a_pin_oe: assert property (p_pin_oe) else $error("status pin enable"); // RULE_08

   sequence s_cmos_lock;
      cfg_word_i[`PCS_BIT_CMOS] && cfg_word_i[63:62] == 2'b00;
   endsequence
   property p_lock_read;
      @(posedge mclk_i) disable iff (rst_i)
      s_cmos_lock ##1 $stable(cfg_word_i) |->
         stat_hi_read_o == $past(stat_i.xtal_locked);
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("lock readback"); // RULE_10

   property p_pin_follow;
      @(posedge mclk_i) disable iff (rst_i)
      cfg_word_i[63:62] == 2'b01 |=> status_program_pin_o
         == $past(stat_i.xtal_range_high);
   endproperty
   a_pin_follow: assert property (p_pin_follow) else $error("range pin"); // RULE_09

   property p_pass;
      @(posedge mclk_i) disable iff (rst_i)
      !cfg_word_i[`PCS_BIT_PHASE_ADJ] && route == pcs_pkg::PCS_RT_XTAL
         |=> diff_clock_out_p_o == $past(clk_i.xtal);
   endproperty
   a_pass: assert property (p_pass) else $error("clock not passed"); // RULE_07

   property p_pump;
      @(posedge mclk_i) disable iff (rst_i)
      main_pump_current_o == 2'b11 |-> pump_na_x10_o == 16'h00F0;
   endproperty
   a_pump: assert property (p_pump) else $error("pump current"); // RULE_12

   property p_filt;
      @(posedge mclk_i) disable iff (rst_i)
      filter_time_sel_o |-> filter_cycles_o == 32'h0000_34BC;
   endproperty
   a_filt: assert property (p_filt) else $error("filter constant"); // RULE_13
endmodule

// File: pcs_clk_model.sv
/*
 Behavioural reference, feedback and core clock sources for the decode block.
 Assumes mclk_i runs at 100 MHz; levels change on its falling edge.
*/
`timescale 1ns/1ns
module pcs_clk_model
(
   // Clock and control.
   input wire logic mclk_i,
   input wire logic hold_i,
   input wire pcs_pkg::pcs_clk_s pat_i,
   // Clock levels.
   output pcs_pkg::pcs_clk_s clk_o
);
   logic [6:0] cnt_ff = 7'h00;
   always @(negedge mclk_i) cnt_ff <= cnt_ff + 7'h01;
   // Free sources run at five rates; xtal shares one with feedback_in_pin and ref_pin one with post_out.
   assign clk_o = hold_i ? pat_i : {cnt_ff[1], cnt_ff[2], cnt_ff[3],
      cnt_ff[1], cnt_ff[4], cnt_ff[2], cnt_ff[0]};
endmodule

// File: tb_top.sv
/*
 Self-checking bench for the configuration decode block.
 Assumes the clock model and the design files are compiled before it.
*/
`timescale 1ns/1ns
`include "pcs_consts.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
$display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
module tb_top;
   logic mclk_i = 1'h0, rst_i = 1'h1, hold = 1'h1;
   logic [63:0] cfg_word_i = '0;
   pcs_pkg::pcs_clk_s clk_i, pat = '0;
   pcs_pkg::pcs_stat_s stat_i = '0;
   logic ref_div_source_sel_o, pd_reference_sel_o, pd_feedback_sel_o;
   logic ref_div_in_o, pd_ref_in_o, pd_fb_in_o, fb_div_in_o, cmos_mode_o;
   logic main_loop_shutdown_o, outside_filter_sel_o, oscillator_style_o;
   logic vco_range_sel_o, filter_time_sel_o, edge_remove_phase_adjust_o;
   logic diff_clock_out_p_o, diff_clock_out_n_o, status_program_pin_o;
   logic status_program_pin_oe_o, stat_hi_read_o;
   logic [1:0] fb_div_source_sel_o, main_pump_current_o, output_route_sel_o;
   logic [15:0] pump_na_x10_o;
   logic [31:0] filter_cycles_o;
   int error_cnt = 0, n_tests = 0;
   always #5 mclk_i = ~mclk_i;
   pcs_clk_model u_src (.mclk_i, .hold_i(hold), .pat_i(pat), .clk_o(clk_i));
   pcs_cfg_select u_dut (.mclk_i, .rst_i, .cfg_word_i, .clk_i, .stat_i,
      .ref_div_source_sel_o, .pd_reference_sel_o, .pd_feedback_sel_o,
      .fb_div_source_sel_o, .ref_div_in_o, .pd_ref_in_o, .pd_fb_in_o,
      .fb_div_in_o, .main_loop_shutdown_o, .outside_filter_sel_o,
      .oscillator_style_o, .vco_range_sel_o, .main_pump_current_o,
      .pump_na_x10_o, .filter_time_sel_o, .filter_cycles_o,
      .output_route_sel_o, .edge_remove_phase_adjust_o, .diff_clock_out_p_o,
      .diff_clock_out_n_o, .cmos_mode_o, .status_program_pin_o,
      .status_program_pin_oe_o, .stat_hi_read_o);
   task automatic wrap_up();
      if (error_cnt == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic put(input logic [63:0] w);
      @(negedge mclk_i);
      cfg_word_i = w;
      #1;
   endtask
   task automatic t_bits();
      int pos [10] = '{12, 13, 14, 15, 42, 43, 44, 45, 48, 60};
      for (int i = 0; i < 10; i++)
      begin
         put(64'h1 << pos[i]);
         `CHK(ref_div_source_sel_o, 1'(pos[i] == 12))
         `CHK(main_loop_shutdown_o, 1'(pos[i] == 13))
         `CHK(pd_reference_sel_o, 1'(pos[i] == 14))
         `CHK(pd_feedback_sel_o, 1'(pos[i] == 15))
         `CHK(outside_filter_sel_o, 1'(pos[i] == 42))
         `CHK(filter_time_sel_o, 1'(pos[i] == 43))
         `CHK(vco_range_sel_o, 1'(pos[i] == 44))
         `CHK(oscillator_style_o, 1'(pos[i] == 45))
         `CHK(edge_remove_phase_adjust_o, 1'(pos[i] == 48))
         `CHK(cmos_mode_o, 1'(pos[i] == 60))
         `CHK(status_program_pin_oe_o, 1'(pos[i] == 60))
      end
   endtask
   task automatic t_paths();
      logic [4:0] k;
      for (int m = 0; m < 32; m++)
      for (int p = 0; p < 7; p++)
      begin
         k = m[4:0];
         @(negedge mclk_i);
         pat = 7'h01 << p;
         put({24'h0, k[4:3], 22'h0, k[2], k[1], 1'h0, k[0], 12'h0});
         `CHK(ref_div_in_o, k[0] ? pat.ref_pin : pat.xtal)
         `CHK(pd_ref_in_o, k[1] ? pat.ref_pin : pat.ref_div)
         `CHK(pd_fb_in_o, k[2] ? pat.feedback_in_pin : pat.fb_div)
         `CHK(fb_div_source_sel_o, k[4:3])
         `CHK(fb_div_in_o, k[3] ? pat.feedback_in_pin :
            (k[4] ? pat.vco : pat.post_out))
      end
   endtask
   task automatic t_codes();
      logic [15:0] na [4] = '{16'h000f, 16'h0032, 16'h0050, 16'h00f0};
      for (int c = 0; c < 4; c++)
      begin
         put(64'(c) << 40);
         `CHK(main_pump_current_o, 2'(c))
         `CHK(pump_na_x10_o, na[c])
      end
      `CHK(filter_cycles_o, 32'(`PCS_FILT_SHORT_NS / `PCS_CLK_NS))
      put(64'h1 << 43);
      `CHK(filter_cycles_o, 32'(`PCS_FILT_LONG_NS / `PCS_CLK_NS))
   endtask
   task automatic t_route();
      pcs_pkg::pcs_clk_s one;
      @(negedge mclk_i);
      for (int r = 0; r < 8; r++)
      for (int v = 0; v < 2; v++)
      begin
         one = 7'h01 << (r[1:0] == 2'h0 ? 0 : r[1:0] == 2'h1 ? 4 :
            r[1:0] == 2'h2 ? 5 : 6);
         pat = v ? one : pcs_pkg::pcs_clk_s'(~one);
         // Bit 14 puts the reference pin on the detector input.
         put({3'h0, r[2], 12'h0, r[1:0], 31'h0, 1'h1, 14'h0});
         @(negedge mclk_i);
         `CHK(output_route_sel_o, r[1:0])
         `CHK(diff_clock_out_p_o, 1'(v))
         `CHK(diff_clock_out_n_o, r[2] ? 1'(v) : 1'(!v))
      end
   endtask
   task automatic t_status();
      logic v;
      logic [1:0] md;
      logic [2:0] s;
      for (int m = 0; m < 8; m++)
      begin
         v = m[0];
         md = m[2:1];
         s = 3'h4 >> md;
         stat_i = v ? s : ~s;
         pat = ((md == 2'h3) == v) ? 7'h04 : 7'h7b;
         put({md, 1'h0, 1'h1, 60'h0});
         @(negedge mclk_i);
         `CHK(status_program_pin_o, v)
         `CHK(stat_hi_read_o, v)
      end
      stat_i = 3'h7;
      put({2'h2, 62'h0});
      @(negedge mclk_i);
      `CHK(status_program_pin_oe_o, 1'h0)
      `CHK(stat_hi_read_o, 1'h1)
      put(64'h0);
      @(negedge mclk_i);
      `CHK(stat_hi_read_o, 1'h0)
   endtask
   task automatic t_reset();
      put({3'h0, 1'h1, 60'h0});
      @(negedge mclk_i);
      `CHK(status_program_pin_o, 1'h1)
      rst_i = 1'h1;
      #1;
      `CHK(diff_clock_out_p_o, 1'h0)
      `CHK(diff_clock_out_n_o, 1'h0)
      `CHK(status_program_pin_o, 1'h0)
      `CHK(stat_hi_read_o, 1'h0)
      `CHK(status_program_pin_oe_o, 1'h1)
      repeat (2) @(negedge mclk_i);
      rst_i = 1'h0;
      @(negedge mclk_i);
      `CHK(status_program_pin_o, 1'h1)
      `CHK(stat_hi_read_o, 1'h1)
   endtask
   task automatic count(output int n);
      logic prev;
      n = 0;
      prev = diff_clock_out_p_o;
      repeat (64)
      begin
         @(negedge mclk_i);
         if (prev === 1'h0 && diff_clock_out_p_o === 1'h1)
            n++;
         prev = diff_clock_out_p_o;
      end
   endtask
   task automatic t_phase();
      int a, b;
      hold = 1'h0;
      put({16'h0, 2'h3, 46'h0});
      count(a);
      put({15'h0, 1'h1, 2'h3, 46'h0});
      count(b);
      `CHK(1'(a >= 15 && a <= 16), 1'h1)
      `CHK(1'(b >= 7 && b <= 9), 1'h1)
      hold = 1'h1;
   endtask
   initial
   begin
      #100000;
      error_cnt++;
      wrap_up();
   end
   initial
   begin
      repeat (20) @(negedge mclk_i);
      `CHK(diff_clock_out_n_o, 1'h1)
      `CHK(stat_hi_read_o, 1'h0)
      rst_i = 1'h0;
      t_bits();
      t_paths();
      t_codes();
      t_route();
      t_status();
      t_reset();
      t_phase();
      wrap_up();
   end
endmodule
